/* hdl/mfs_pkg.sv */
// package: instruction fields, opcodes, special-register numbers, shared types
package mfs_pkg;
	localparam logic [5:0] OP_PRIMARY = 6'h1f;
	localparam logic [9:0] XO_READ_MSR = 10'h053;
	localparam logic [9:0] XO_READ_COND = 10'h013;
	localparam logic [9:0] XO_READ_SPR = 10'h153;
	localparam logic [9:0] XO_READ_SEG = 10'h253;
	localparam logic [9:0] XO_READ_SEG_IND = 10'h273;
	localparam logic [9:0] SPR_FIXED_EXC = 10'h001;
	localparam logic [9:0] SPR_LINK = 10'h008;
	localparam logic [9:0] SPR_COUNT = 10'h009;
	localparam logic [9:0] SPR_FAULT_CAUSE = 10'h012;
	localparam logic [9:0] SPR_FAULT_ADDR = 10'h013;
	localparam logic [9:0] SPR_TIMER_NEW = 10'h016;
	localparam logic [9:0] SPR_PAGE_BASE = 10'h019;
	localparam logic [9:0] SPR_SAVE_ZERO = 10'h01a;
	localparam logic [9:0] SPR_SAVE_ONE = 10'h01b;
	localparam logic [9:0] SPR_SCRATCH_LO = 10'h110;
	localparam logic [9:0] SPR_SCRATCH_HI = 10'h113;
	localparam logic [9:0] SPR_EXT_ACCESS = 10'h11a;
	localparam logic [9:0] SPR_TB_LOW = 10'h11c;
	localparam logic [9:0] SPR_TB_HIGH = 10'h11d;
	localparam logic [9:0] SPR_XLATE_LO = 10'h210;
	localparam logic [9:0] SPR_XLATE_HI = 10'h21f;
	localparam logic [9:0] SPR_MUL_QUOT = 10'h000;
	localparam logic [9:0] SPR_CLOCK_HIGH = 10'h004;
	localparam logic [9:0] SPR_CLOCK_LOW = 10'h005;
	localparam logic [9:0] SPR_TIMER_OLD = 10'h006;
	localparam logic [4:0] REG_ZERO = 5'h00;
	localparam logic [31:0] WORD_ZERO = 32'h0000_0000;
	localparam logic [1:0] BUS_OKAY = 2'h0;

	// decoded form of an instruction word, bit 0 is the msb
	typedef struct packed {
		logic [5:0] primary;
		logic [4:0] dest;
		logic [4:0] field_a;
		logic [4:0] field_b;
		logic [9:0] ext;
		logic record_bit;
	} instr_t;

	typedef struct packed {
		logic valid;
		logic [4:0] idx;
		logic [31:0] data;
	} gpr_write_t;
endpackage

/* hdl/spr_decode.sv */
// special-register number rebuild and classification
`timescale 1ns/1ns
`default_nettype none
module spr_decode (
	// raw split field and variant
	input wire logic [9:0] spr_field,
	input wire logic newer_arch,
	// classification
	output logic [9:0] spr_num,
	output logic spr_known,
	output logic spr_priv
);
	always_comb
	begin
		spr_num = {spr_field[4:0], spr_field[9:5]};
		spr_known = 1'b1;
		spr_priv = 1'b1;
		if (spr_num == mfs_pkg::SPR_FIXED_EXC || spr_num == mfs_pkg::SPR_LINK
			|| spr_num == mfs_pkg::SPR_COUNT)
		begin
			spr_priv = 1'b0;
		end
		else if (spr_num == mfs_pkg::SPR_FAULT_CAUSE || spr_num == mfs_pkg::SPR_FAULT_ADDR
			|| (spr_num >= mfs_pkg::SPR_PAGE_BASE && spr_num <= mfs_pkg::SPR_SAVE_ONE)
			|| (spr_num >= mfs_pkg::SPR_SCRATCH_LO && spr_num <= mfs_pkg::SPR_SCRATCH_HI)
			|| spr_num == mfs_pkg::SPR_EXT_ACCESS || spr_num == mfs_pkg::SPR_TB_LOW
			|| spr_num == mfs_pkg::SPR_TB_HIGH
			|| (spr_num >= mfs_pkg::SPR_XLATE_LO && spr_num <= mfs_pkg::SPR_XLATE_HI))
		begin
			spr_priv = 1'b1;
		end
		else if (spr_num == mfs_pkg::SPR_TIMER_NEW && newer_arch)
		begin
			spr_priv = 1'b1;
		end
		else if (spr_num == mfs_pkg::SPR_TIMER_OLD && !newer_arch)
		begin
			spr_priv = 1'b0;
		end
		else if ((spr_num == mfs_pkg::SPR_MUL_QUOT || spr_num == mfs_pkg::SPR_CLOCK_HIGH
			|| spr_num == mfs_pkg::SPR_CLOCK_LOW) && !newer_arch)
		begin
			spr_priv = 1'b0;
		end
		else
		begin
			spr_known = 1'b0;
			spr_priv = 1'b0;
		end
	end
endmodule
`default_nettype wire

/* hdl/move_from_special_regs.sv */
// move-from instruction decode and execute, with AHB-Lite staging registers
//
// What this block does
// - read-machine-state copies state register to destination, exception and cr0 untouched.
// - read-machine-state is primary 31, extended 83, destination in bits 6-10.
// - machine-state and direct segment reads privileged only in newer variant.
// - one-field read: primary 31, bit 11 set, mask 12-19, extended 19.
// - mask bit 12 selects cr 0-3 up to bit 19 for 28-31, same place.
// - bit 11 clear copies the whole condition register.
// - special read: primary 31, number in 11-20, extended 339.
// - special number is built by swapping the two 5-bit halves.
// - numbers 1, 8, 9 free; listed system numbers need privilege.
// - newer variant serves timer at 22, privileged.
// - older variant serves timer at 6, unprivileged.
// - older variant only: quotient at 0, clock halves at 4 and 5.
// - an unlisted special number is an invalid form.
// - special read leaves exception register and cr0 unchanged.
// - direct segment read: extended 595, segment field picks source.
// - direct segment read keeps exception register; record may leave cr0 undefined.
// - older variant only: indirect segment read, extended 627, three operand fields.
// - nonzero base: base plus addend written to base, top 4 bits pick segment.
// - base field equal to destination field skips the sum write-back.
// - indirect read keeps exception register; record may leave cr0 undefined.
//
// Our own choices: the placing of the registers and the AHB-Lite slave port.
`timescale 1ns/1ns
`default_nettype none
module move_from_special_regs (
	// clock and reset
	input wire logic clk_sys,
	input wire logic resetn,
	// instruction issue from decode
	input wire logic issue_valid,
	input wire logic [31:0] issue_word,
	input wire logic user_state,
	// general-register read ports
	output logic [4:0] gpr_rd_a_idx,
	output logic [4:0] gpr_rd_b_idx,
	input wire logic [31:0] gpr_rd_a_data,
	input wire logic [31:0] gpr_rd_b_data,
	// architectural sources
	input wire logic [31:0] machine_state_reg,
	input wire logic [31:0] condition_reg,
	input wire logic [31:0] spr_rd_data,
	input wire logic [31:0] segment_rd_data,
	output logic [9:0] spr_rd_num,
	output logic [3:0] segment_index,
	// results
	output mfs_pkg::gpr_write_t dest_write,
	output mfs_pkg::gpr_write_t base_write,
	output logic priv_exception,
	output logic invalid_form,
	output logic cr0_undefined,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp
);
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_STATUS = 8'h04;
	localparam logic [7:0] ADDR_COUNT = 8'h08;
	localparam int CTRL_NEWER_BIT = 0;

	typedef enum logic [2:0]
	{
		ST_IDLE = 3'b001,
		ST_EXEC = 3'b010,
		ST_DONE = 3'b100
	} state_t;

	function automatic logic onehot8(input logic [7:0] m);
		onehot8 = (m != 8'h00) && ((m & (m - 8'h01)) == 8'h00);
	endfunction

	// instruction field extraction; bit 0 of the word is its msb
	mfs_pkg::instr_t ins;
	assign ins = issue_word;

	state_t state_q, state_d;
	mfs_pkg::instr_t ins_q, ins_d;
	logic user_q, user_d;
	logic newer_q, newer_d;
	logic [31:0] exec_count_q, exec_count_d;
	logic [3:0] last_status_q, last_status_d;
	mfs_pkg::gpr_write_t dest_q, dest_d, base_q, base_d;
	logic priv_q, priv_d, inval_q, inval_d, cr0u_q, cr0u_d;
	logic [31:0] hrdata_q, hrdata_d;
	logic ph_wr_q, ph_wr_d, ph_rd_q, ph_rd_d;
	logic [7:0] ph_addr_q, ph_addr_d;

	logic [9:0] spr_num;
	logic spr_known, spr_priv;
	logic [31:0] sum;
	logic [7:0] mask;
	logic [31:0] lane_sel;

	spr_decode u_spr (
		.spr_field({ins_q.field_a, ins_q.field_b}),
		.newer_arch(newer_q),
		.spr_num(spr_num),
		.spr_known(spr_known),
		.spr_priv(spr_priv)
	);

	assign sum = gpr_rd_a_data + gpr_rd_b_data;
	assign mask = {ins_q.field_a[3:0], ins_q.field_b[4:1]};
	always_comb
	begin
		for (int i = 0; i < 8; i++)
		begin
			lane_sel[31 - 4 * i -: 4] = {4{mask[7 - i]}};
		end
	end

	// operand routing uses the held instruction during execute
	assign gpr_rd_a_idx = ins_q.field_a;
	assign gpr_rd_b_idx = ins_q.field_b;
	assign spr_rd_num = spr_num;
	assign segment_index = (ins_q.ext == mfs_pkg::XO_READ_SEG_IND) ? sum[31:28]
		: ins_q.field_a[3:0];

	always_comb
	begin
		state_d = state_q;
		ins_d = ins_q;
		user_d = user_q;
		exec_count_d = exec_count_q;
		last_status_d = last_status_q;
		dest_d = '0;
		base_d = '0;
		priv_d = 1'b0;
		inval_d = 1'b0;
		cr0u_d = 1'b0;
		case (state_q)
			ST_IDLE:
			begin
				if (issue_valid && ins.primary == mfs_pkg::OP_PRIMARY)
				begin
					ins_d = ins;
					user_d = user_state;
					state_d = ST_EXEC;
				end
			end
			ST_EXEC:
			begin
				logic is_priv;
				logic bad;
				logic [31:0] val;
				is_priv = 1'b0;
				bad = 1'b0;
				val = mfs_pkg::WORD_ZERO;
				case (ins_q.ext)
					mfs_pkg::XO_READ_MSR:
					begin
						val = machine_state_reg;
						is_priv = newer_q;
					end
					mfs_pkg::XO_READ_COND:
					begin
						if (ins_q.field_a[4])
						begin
							bad = !onehot8(mask);
							val = condition_reg & lane_sel;
						end
						else
						begin
							val = condition_reg;
						end
					end
					mfs_pkg::XO_READ_SPR:
					begin
						val = spr_rd_data;
						bad = !spr_known;
						is_priv = spr_priv;
					end
					mfs_pkg::XO_READ_SEG:
					begin
						val = segment_rd_data;
						is_priv = newer_q;
						cr0u_d = ins_q.record_bit;
					end
					mfs_pkg::XO_READ_SEG_IND:
					begin
						bad = newer_q;
						val = segment_rd_data;
						cr0u_d = ins_q.record_bit;
						base_d.valid = !newer_q && ins_q.field_a != mfs_pkg::REG_ZERO
							&& ins_q.field_a != ins_q.dest;
						base_d.idx = ins_q.field_a;
						base_d.data = sum;
					end
					default:
					begin
						bad = 1'b1;
					end
				endcase
				if (bad)
				begin
					inval_d = 1'b1;
					base_d.valid = 1'b0;
					cr0u_d = 1'b0;
				end
				else if (is_priv && user_q)
				begin
					priv_d = 1'b1;
					base_d.valid = 1'b0;
					cr0u_d = 1'b0;
				end
				else
				begin
					dest_d.valid = 1'b1;
					dest_d.idx = ins_q.dest;
					dest_d.data = val;
				end
				exec_count_d = exec_count_q + 32'h0000_0001;
				last_status_d = {bad, is_priv && user_q && !bad, cr0u_d, !bad && !(is_priv && user_q)};
				state_d = ST_DONE;
			end
			ST_DONE:
			begin
				state_d = ST_IDLE;
			end
			default:
			begin
				state_d = ST_IDLE;
			end
		endcase
	end

	// bus slave: zero wait states, unmapped reads return zero
	always_comb
	begin
		logic take;
		take = hsel && hready && htrans[1];
		ph_wr_d = take && hwrite;
		ph_rd_d = take && !hwrite;
		ph_addr_d = take ? haddr[7:0] : ph_addr_q;
		newer_d = newer_q;
		if (ph_wr_q && ph_addr_q == ADDR_CTRL)
		begin
			newer_d = hwdata[CTRL_NEWER_BIT];
		end
		hrdata_d = mfs_pkg::WORD_ZERO;
		if (ph_rd_d)
		begin
			case (haddr[7:0])
				ADDR_CTRL: hrdata_d = {31'h0000_0000, newer_d};
				ADDR_STATUS: hrdata_d = {28'h000_0000, last_status_q};
				ADDR_COUNT: hrdata_d = exec_count_q;
				default: hrdata_d = mfs_pkg::WORD_ZERO;
			endcase
		end
	end

	always_ff @(posedge clk_sys)
	begin
		if (!resetn)
		begin
			state_q <= ST_IDLE;
			ins_q <= '0;
			user_q <= 1'b0;
			newer_q <= 1'b1;
			exec_count_q <= mfs_pkg::WORD_ZERO;
			last_status_q <= 4'h0;
			dest_q <= '0;
			base_q <= '0;
			priv_q <= 1'b0;
			inval_q <= 1'b0;
			cr0u_q <= 1'b0;
			hrdata_q <= mfs_pkg::WORD_ZERO;
			ph_wr_q <= 1'b0;
			ph_rd_q <= 1'b0;
			ph_addr_q <= 8'h00;
		end
		else
		begin
			state_q <= state_d;
			ins_q <= ins_d;
			user_q <= user_d;
			newer_q <= newer_d;
			exec_count_q <= exec_count_d;
			last_status_q <= last_status_d;
			dest_q <= dest_d;
			base_q <= base_d;
			priv_q <= priv_d;
			inval_q <= inval_d;
			cr0u_q <= cr0u_d;
			hrdata_q <= hrdata_d;
			ph_wr_q <= ph_wr_d;
			ph_rd_q <= ph_rd_d;
			ph_addr_q <= ph_addr_d;
		end
	end

	assign dest_write = dest_q;
	assign base_write = base_q;
	assign priv_exception = priv_q;
	assign invalid_form = inval_q;
	assign cr0_undefined = cr0u_q;
	assign hrdata = hrdata_q;
	assign hreadyout = 1'b1;
	assign hresp = mfs_pkg::BUS_OKAY[0];

	a_priv_blocks_write: assert property (@(posedge clk_sys) disable iff (!resetn)
		priv_q |-> !dest_q.valid && !base_q.valid)
		else $error("privileged fault with a register write");
	a_user_priv_fault: assert property (@(posedge clk_sys) disable iff (!resetn)
		state_q == ST_EXEC && user_q && newer_q && ins_q.ext == mfs_pkg::XO_READ_MSR
		|=> priv_q)
		else $error("user state state-register read not faulted");
	a_msr_copy: assert property (@(posedge clk_sys) disable iff (!resetn)
		state_q == ST_EXEC && !user_q && ins_q.ext == mfs_pkg::XO_READ_MSR
		|=> dest_q.valid && dest_q.data == $past(machine_state_reg)
		&& dest_q.idx == $past(ins_q.dest))
		else $error("state register not copied to destination");
	a_whole_cond: assert property (@(posedge clk_sys) disable iff (!resetn)
		state_q == ST_EXEC && ins_q.ext == mfs_pkg::XO_READ_COND && !ins_q.field_a[4]
		|=> dest_q.data == $past(condition_reg))
		else $error("condition register copy wrong");
	a_mask_invalid: assert property (@(posedge clk_sys) disable iff (!resetn)
		state_q == ST_EXEC && ins_q.ext == mfs_pkg::XO_READ_COND && ins_q.field_a[4]
		&& mask == 8'h00 |=> inval_q && !dest_q.valid)
		else $error("empty mask not invalid");
	a_spr_unknown: assert property (@(posedge clk_sys) disable iff (!resetn)
		state_q == ST_EXEC && ins_q.ext == mfs_pkg::XO_READ_SPR && !spr_known
		|=> inval_q)
		else $error("unlisted special number accepted");
	a_base_skip: assert property (@(posedge clk_sys) disable iff (!resetn)
		base_q.valid |-> base_q.idx != dest_q.idx && base_q.idx != mfs_pkg::REG_ZERO)
		else $error("base written when equal to destination or zero");
	a_ind_older_only: assert property (@(posedge clk_sys) disable iff (!resetn)
		state_q == ST_EXEC && newer_q && ins_q.ext == mfs_pkg::XO_READ_SEG_IND
		|=> inval_q ##1 !inval_q)
		else $error("indirect segment read accepted in newer variant");
endmodule
`default_nettype wire

/* test/move_from_special_regs_test.sv */
// self-checking bench for the move-from decode and execute block
`timescale 1ns/1ns
`default_nettype none
module move_from_special_regs_test;
	logic clk_sys;
	logic resetn;
	logic issue_valid;
	logic [31:0] issue_word;
	logic user_state;
	logic [4:0] gpr_rd_a_idx;
	logic [4:0] gpr_rd_b_idx;
	logic [31:0] gpr_rd_a_data;
	logic [31:0] gpr_rd_b_data;
	logic [31:0] machine_state_reg;
	logic [31:0] condition_reg;
	logic [31:0] spr_rd_data;
	logic [31:0] segment_rd_data;
	logic [9:0] spr_rd_num;
	logic [3:0] segment_index;
	mfs_pkg::gpr_write_t dest_write;
	mfs_pkg::gpr_write_t base_write;
	logic priv_exception;
	logic invalid_form;
	logic cr0_undefined;
	logic hsel;
	logic [31:0] haddr;
	logic [1:0] htrans;
	logic hwrite;
	logic [2:0] hsize;
	logic [31:0] hwdata;
	logic hready;
	logic [31:0] hrdata;
	logic hreadyout;
	logic hresp;
	mfs_pkg::gpr_write_t dw;
	mfs_pkg::gpr_write_t bw;
	logic [2:0] fl;
	logic [31:0] rd;
	logic [9:0] n;
	logic [7:0] m;
	logic [31:0] grp;
	int miscompares = 0;
	int n_tests = 0;
	int cycles = 0;
	int free_n[3] = '{1, 8, 9};
	int priv_n[8] = '{18, 19, 22, 25, 272, 282, 285, 543};
	int bad_n[4] = '{0, 2, 6, 544};
	int old_n[4] = '{0, 4, 5, 6};

	// register files answer in the same cycle, values derived from the index
	assign gpr_rd_a_data = {gpr_rd_a_idx[3:0], 28'h000_3000};
	assign gpr_rd_b_data = {gpr_rd_b_idx[3:0], 28'h000_0000};
	assign spr_rd_data = {16'hc0de, 6'h00, spr_rd_num};
	assign segment_rd_data = {28'h5e6_0000, segment_index};
	assign hready = hreadyout;

	move_from_special_regs u_move_from_special_regs (.clk_sys(clk_sys), .resetn(resetn),
		.issue_valid(issue_valid), .issue_word(issue_word), .user_state(user_state),
		.gpr_rd_a_idx(gpr_rd_a_idx), .gpr_rd_b_idx(gpr_rd_b_idx),
		.gpr_rd_a_data(gpr_rd_a_data), .gpr_rd_b_data(gpr_rd_b_data),
		.machine_state_reg(machine_state_reg), .condition_reg(condition_reg),
		.spr_rd_data(spr_rd_data), .segment_rd_data(segment_rd_data),
		.spr_rd_num(spr_rd_num), .segment_index(segment_index),
		.dest_write(dest_write), .base_write(base_write), .priv_exception(priv_exception),
		.invalid_form(invalid_form), .cr0_undefined(cr0_undefined), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp));

	function automatic logic [31:0] mk(input logic [9:0] xo, input logic [4:0] rt,
		input logic [4:0] fa, input logic [4:0] fb, input logic rc);
		mk = {mfs_pkg::OP_PRIMARY, rt, fa, fb, xo, rc};
	endfunction

	function automatic mfs_pkg::gpr_write_t wr(input logic [4:0] idx, input logic [31:0] d);
		wr = {1'b1, idx, d};
	endfunction

	function automatic logic [31:0] seg(input logic [3:0] i);
		seg = {28'h5e6_0000, i};
	endfunction

	task automatic test_done();
		if (miscompares == 0 && n_tests > 0)
		begin
			$display("Regression OK");
		end
		else
		begin
			$display("Regression broken");
		end
		$finish;
	endtask

	task automatic chk(input logic [127:0] got, input logic [127:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			miscompares++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// one instruction; results sampled in the single cycle they stand
	task automatic run(input logic [31:0] w, input logic usr);
		@(posedge clk_sys);
		issue_valid <= 1'b1;
		issue_word <= w;
		user_state <= usr;
		@(posedge clk_sys);
		issue_valid <= 1'b0;
		@(posedge clk_sys);
		#1;
		dw = dest_write;
		bw = base_write;
		fl = {priv_exception, invalid_form, cr0_undefined};
	endtask

	task automatic ahb(input logic we, input logic [31:0] a, input logic [31:0] d,
		output logic [31:0] r);
		@(posedge clk_sys);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= we;
		hsize <= 3'h2;
		@(posedge clk_sys);
		while (hready !== 1'b1) @(posedge clk_sys);
		htrans <= 2'h0;
		hwdata <= d;
		@(posedge clk_sys);
		while (hready !== 1'b1) @(posedge clk_sys);
		r = hrdata;
	endtask

	initial
	begin
		clk_sys = 1'b0;
		forever #2 clk_sys = ~clk_sys;
	end

	// ceiling well above the under two hundred cycles the sequence needs
	always @(posedge clk_sys)
	begin
		cycles++;
		if (cycles == 3000)
		begin
			miscompares++;
			test_done();
		end
	end

	initial
	begin
		resetn = 1'b0;
		issue_valid = 1'b0;
		issue_word = 32'h0000_0000;
		user_state = 1'b0;
		machine_state_reg = 32'h0000_b032;
		condition_reg = 32'h4055_f605;
		hsel = 1'b0;
		haddr = 32'h0000_0000;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0000_0000;
		repeat (10) @(posedge clk_sys);
		resetn <= 1'b1;
		chk({dest_write, base_write, priv_exception, invalid_form, cr0_undefined}, 0);
		ahb(1'b0, 32'h0000_0000, 0, rd);
		chk(rd, 32'h0000_0001);
		ahb(1'b0, 32'h0000_0004, 0, rd);
		chk(rd, 32'h0000_0000);
		run(mk(mfs_pkg::XO_READ_MSR, 5'd4, 5'd0, 5'd0, 1'b0), 1'b0);
		chk({dw, fl}, {wr(5'd4, machine_state_reg), 3'h0});
		run(mk(mfs_pkg::XO_READ_MSR, 5'd4, 5'd0, 5'd0, 1'b0), 1'b1);
		chk({dw.valid, fl}, {1'b0, 3'h4});
		run(mk(mfs_pkg::XO_READ_COND, 5'd6, 5'd0, 5'd0, 1'b0), 1'b1);
		chk(dw, wr(5'd6, condition_reg));
		for (int k = 0; k < 8; k++)
		begin
			m = 8'h80 >> k;
			grp = 32'hf000_0000 >> (4 * k);
			run(mk(mfs_pkg::XO_READ_COND, 5'd7, {1'b1, m[7:4]}, {m[3:0], 1'b0}, 1'b0), 1'b1);
			chk({dw.valid, dw.idx, dw.data & grp}, {6'h27, condition_reg & grp});
		end
		run(mk(mfs_pkg::XO_READ_COND, 5'd7, 5'h10, 5'h00, 1'b0), 1'b1);
		chk({dw.valid, fl}, {1'b0, 3'h2});
		run(mk(mfs_pkg::XO_READ_COND, 5'd7, 5'h11, 5'h10, 1'b0), 1'b1);
		chk({dw.valid, fl}, {1'b0, 3'h2});
		for (int k = 0; k < 3; k++)
		begin
			n = 10'(free_n[k]);
			run(mk(mfs_pkg::XO_READ_SPR, 5'd3, n[4:0], n[9:5], 1'b0), 1'b1);
			chk({dw, fl}, {wr(5'd3, {16'hc0de, 6'h00, n}), 3'h0});
		end
		for (int k = 0; k < 8; k++)
		begin
			n = 10'(priv_n[k]);
			run(mk(mfs_pkg::XO_READ_SPR, 5'd3, n[4:0], n[9:5], 1'b0), 1'b1);
			chk({dw.valid, fl}, {1'b0, 3'h4});
			run(mk(mfs_pkg::XO_READ_SPR, 5'd3, n[4:0], n[9:5], 1'b0), 1'b0);
			chk({dw, fl}, {wr(5'd3, {16'hc0de, 6'h00, n}), 3'h0});
		end
		for (int k = 0; k < 4; k++)
		begin
			n = 10'(bad_n[k]);
			run(mk(mfs_pkg::XO_READ_SPR, 5'd3, n[4:0], n[9:5], 1'b0), 1'b1);
			chk({dw.valid, fl}, {1'b0, 3'h2});
		end
		run(mk(mfs_pkg::XO_READ_SEG, 5'd8, 5'h07, 5'd0, 1'b1), 1'b0);
		chk({dw, fl}, {wr(5'd8, seg(4'h7)), 3'h1});
		run(mk(mfs_pkg::XO_READ_SEG, 5'd8, 5'h07, 5'd0, 1'b0), 1'b1);
		chk({dw.valid, fl}, {1'b0, 3'h4});
		run(mk(mfs_pkg::XO_READ_SEG_IND, 5'd6, 5'd5, 5'd4, 1'b0), 1'b0);
		chk({dw.valid, bw.valid, fl}, {2'h0, 3'h2});
		ahb(1'b0, 32'h0000_0004, 0, rd);
		chk(rd, 32'h0000_0008);
		ahb(1'b1, 32'h0000_0004, 32'h0000_000f, rd);
		ahb(1'b0, 32'h0000_0004, 0, rd);
		chk(rd, 32'h0000_0008);
		ahb(1'b0, 32'h0000_0040, 0, rd);
		chk({rd, hresp}, 33'h0_0000_0000);
		ahb(1'b1, 32'h0000_0000, 32'h0000_0000, rd);
		ahb(1'b0, 32'h0000_0000, 0, rd);
		chk(rd, 32'h0000_0000);
		run(mk(mfs_pkg::XO_READ_MSR, 5'd4, 5'd0, 5'd0, 1'b0), 1'b1);
		chk({dw, fl}, {wr(5'd4, machine_state_reg), 3'h0});
		for (int k = 0; k < 4; k++)
		begin
			n = 10'(old_n[k]);
			run(mk(mfs_pkg::XO_READ_SPR, 5'd3, n[4:0], n[9:5], 1'b0), 1'b1);
			chk({dw, fl}, {wr(5'd3, {16'hc0de, 6'h00, n}), 3'h0});
		end
		run(mk(mfs_pkg::XO_READ_SEG, 5'd8, 5'h03, 5'd0, 1'b0), 1'b1);
		chk({dw, fl}, {wr(5'd8, seg(4'h3)), 3'h0});
		run(mk(mfs_pkg::XO_READ_SEG_IND, 5'd6, 5'd5, 5'd4, 1'b1), 1'b1);
		chk({dw, bw, fl}, {wr(5'd6, seg(4'h9)), wr(5'd5, 32'h9000_3000), 3'h1});
		run(mk(mfs_pkg::XO_READ_SEG_IND, 5'd5, 5'd5, 5'd4, 1'b0), 1'b1);
		chk({dw, bw.valid}, {wr(5'd5, seg(4'h9)), 1'b0});
		test_done();
	end
endmodule
`default_nettype wire
